// >>> mft_cfg.svh
// Register indices, field positions and reset values of the output B / flag / DMA block.
`ifndef MFT_CFG_SVH
`define MFT_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define MFT_IDX_DCP   8'hf0
`define MFT_IDX_DAP   8'hf1
`define MFT_IDX_IVR   8'hf2
`define MFT_IDX_OBC   8'hfd
`define MFT_IDX_FLG   8'hfe
`define MFT_IDX_MSK   8'hff
`define MFT_ADR_IDX   9:2
`define MFT_RD_PAD    24'h000000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MFT_OB_C0A    7:6
`define MFT_OB_C1A    5:4
`define MFT_OB_WRA    3:2
`define MFT_OB_CEV    1
`define MFT_OB_PIN    0
`define MFT_FL_CP0    7
`define MFT_FL_CP1    6
`define MFT_FL_CM0    5
`define MFT_FL_CM1    4
`define MFT_FL_WRP    3
`define MFT_FL_CAPTURE0_OVERRUN   2
`define MFT_FL_COMPARE0_OVERRUN   1
`define MFT_FL_A0     0
`define MFT_FL_HW     7:1
`define MFT_MK_GT     7
`define MFT_MK_CAPTURE0_DMA_EN   6
`define MFT_MK_CAPTURE0_IRQ_MASK   5
`define MFT_MK_CAPTURE1_IRQ_MASK   4
`define MFT_MK_COMPARE0_DMA_EN   3
`define MFT_MK_COMPARE0_IRQ_MASK   2
`define MFT_MK_COMPARE1_IRQ_MASK   1
`define MFT_MK_OUI    0
`define MFT_DP_HI     7:2
`define MFT_DP_TGL    2
`define MFT_DP_IND    1
`define MFT_DP_SEL    0
`define MFT_IV_SW     7:3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MFT_RST8      8'h00
`define MFT_RST5      5'h00
`define MFT_RST7      7'h00

`endif

// >>> mft_pkg.sv
// Types shared by the output B / flag / DMA block.
package mft_pkg;
    typedef enum logic [1:0] {
        MFT_SET = 2'b00,
        MFT_TGL = 2'b01,
        MFT_CLR = 2'b10,
        MFT_NOP = 2'b11
    } mft_act_e;
    typedef enum logic [1:0] {
        MFT_GRP_WRAP = 2'b00,
        MFT_GRP_NONE = 2'b01,
        MFT_GRP_CAP  = 2'b10,
        MFT_GRP_CMP  = 2'b11
    } mft_grp_e;
endpackage

// >>> mft_outb_flags_irq_dma_ctl.sv
// Output B pin control, event flags, interrupt/DMA masks, DMA pointers and vector of one timer.
`timescale 1ns/1ps
`include "mft_cfg.svh"
// ----------------------------------------------------------------
// Overview of operation
// - Compare 0 match applies bits 7:6 action.
// - Compare 1 match applies bits 5:4 action.
// - Counter wrap applies bits 3:2 action.
// - Simultaneous events apply ANDed action codes.
// - Wrap pulses chip event while bit1 set.
// - Bit 0 presets pin; reads pin state.
// - Capture 0 flag set by hardware; write-one captures.
// - Capture 1 flag; write-one captures unless bicapture.
// - Capture interrupt ORs or ANDs both captures.
// - Compare 0 flag interrupts when enabled.
// - Compare 1 flag interrupts when enabled.
// - Wrap flag interrupts when enabled.
// - Capture 0 overrun on repeat or software capture.
// - Compare 0 overrun on repeat while flagged.
// - Global enable gates all timer interrupts.
// - Capture DMA enable, cleared at end of block.
// - Compare DMA enable, cleared at end of block.
// - Mask bits 4,1,0 enable their sources.
// - Counter pointer high bits, toggle, channel indicator.
// - Address pointer high bits, toggle in swap.
// - Area select and segment select steer DMA.
// - Vector holds software bits, group code, zero.
// - Swap enable allows table toggling.
// ----------------------------------------------------------------
module mft_outb_flags_irq_dma_ctl (
    input  wire logic        SYS_CLK,        // System clock, 20 MHz.
    input  wire logic        RSTN,           // Asynchronous reset, active low.
    input  wire logic        WB_CYC_I,       // Wishbone cycle.
    input  wire logic        WB_STB_I,       // Wishbone strobe.
    input  wire logic        WB_WE_I,        // Wishbone write enable.
    input  wire logic [9:0]  WB_ADR_I,       // Wishbone byte address.
    input  wire logic [3:0]  WB_SEL_I,       // Wishbone byte selects.
    input  wire logic [31:0] WB_DAT_I,       // Wishbone write data.
    output logic      [31:0] WB_DAT_O,       // Wishbone read data.
    output logic             WB_ACK_O,       // Wishbone acknowledge.
    input  wire logic        CMP0_MATCH,     // Compare 0 match strobe.
    input  wire logic        CMP1_MATCH,     // Compare 1 match strobe.
    input  wire logic        CNT_WRAP,       // Counter overflow/underflow strobe.
    input  wire logic        CAP0_EVT,       // Capture into register 0 strobe.
    input  wire logic        CAP1_EVT,       // Capture into register 1 strobe.
    input  wire logic        BICAPTURE_MODE, // Bicapture mode selected.
    input  wire logic        TABLE_SWAP_EN,  // Swap mode for both DMA channels.
    input  wire logic        CAP0_DMA_EOB,   // Capture 0 DMA end of block strobe.
    input  wire logic        CMP0_DMA_EOB,   // Compare 0 DMA end of block strobe.
    input  wire logic        IRQ_ACK,        // Controller acknowledge strobe.
    output logic             OUTPUT_PIN_B,   // Output pin B level.
    output logic             CHIP_EVENT,     // On-chip event pulse.
    output logic             IRQ_REQ,        // Interrupt request line.
    output logic      [7:0]  IRQ_VECTOR,     // Vector latched at acknowledge.
    output logic             CAP0_DMA_REQ,   // Capture 0 DMA request pulse.
    output logic             CMP0_DMA_REQ,   // Compare 0 DMA request pulse.
    output logic             SW_CAP0_LOAD,   // Software capture/load pulse, register 0.
    output logic             SW_CAP1,        // Software capture pulse, register 1.
    output logic             DMA_TO_REGFILE, // DMA targets the register file.
    output logic             DMA_USE_DMASEG, // Memory DMA extended by DMA segment reg.
    output logic             DMA_CHAN_IND    // 0 capture 0 source, 1 compare 0 dest.
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0]              obc;
    logic [7:0]              flg;
    logic [7:0]              msk;
    logic [7:0]              dcp;
    logic [7:0]              dap;
    logic [4:0]              ivr_sw;
    mft_pkg::mft_grp_e       grp;
    logic                    eob_cap;
    logic                    eob_cmp;

    logic                    bus_req;
    logic                    bus_wr;
    logic [7:0]              bus_idx;
    logic                    wr_obc;
    logic                    wr_flg;
    logic                    wr_msk;
    logic                    wr_dcp;
    logic                    wr_dap;
    logic                    wr_ivr;
    logic [1:0]              act;
    logic                    next_pin;
    logic                    sw_cap0;
    logic                    sw_cap1;
    logic                    cap0_ev;
    logic                    cap1_ev;
    logic [7:1]              hw_set;
    logic [7:1]              sw_clr;
    logic [7:0]              next_flg;
    logic [7:0]              next_msk;
    logic                    c0_rq;
    logic                    c1_rq;
    logic                    cap_rq;
    logic                    cmp_rq;
    logic                    wrp_rq;
    logic                    any_rq;
    mft_pkg::mft_grp_e       next_grp;
    logic                    dma_c_req;
    logic                    dma_m_req;
    logic                    any_eob;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic apply_act(input logic [1:0] a, input logic p);
        logic r;
        r = p;
        unique case (mft_pkg::mft_act_e'(a))
            mft_pkg::MFT_SET: r = 1'b1;
            mft_pkg::MFT_TGL: r = ~p;
            mft_pkg::MFT_CLR: r = 1'b0;
            mft_pkg::MFT_NOP: r = p;
        endcase
        return r;
    endfunction

    // The strobe and index are passed in so that every caller follows the bus.
    function automatic logic hit(input logic wr, input logic [7:0] idx, input logic [7:0] want);
        return wr && (idx == want);
    endfunction

    // Pointer update: swap toggle, software write, then channel indicator.
    function automatic logic [7:0] ptr_next(input logic [7:0] cur, input logic wr);
        logic [7:0] p;
        p = cur;
        if (TABLE_SWAP_EN && any_eob) begin
            p[`MFT_DP_TGL] = ~cur[`MFT_DP_TGL];
        end
        if (wr) begin
            p[`MFT_DP_HI] = WB_DAT_I[`MFT_DP_HI];
            p[`MFT_DP_SEL] = WB_DAT_I[`MFT_DP_SEL];
        end
        if (dma_m_req) begin
            p[`MFT_DP_IND] = 1'b1;
        end else if (dma_c_req) begin
            p[`MFT_DP_IND] = 1'b0;
        end
        return p;
    endfunction

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // A write takes effect at the edge where the master sees the acknowledge.
    assign bus_req = WB_CYC_I && WB_STB_I;
    assign bus_wr  = bus_req && WB_WE_I && WB_ACK_O && WB_SEL_I[0];
    assign bus_idx = WB_ADR_I[`MFT_ADR_IDX];
    assign wr_obc  = hit(bus_wr, bus_idx, `MFT_IDX_OBC);
    assign wr_flg  = hit(bus_wr, bus_idx, `MFT_IDX_FLG);
    assign wr_msk  = hit(bus_wr, bus_idx, `MFT_IDX_MSK);
    assign wr_dcp  = hit(bus_wr, bus_idx, `MFT_IDX_DCP);
    assign wr_dap  = hit(bus_wr, bus_idx, `MFT_IDX_DAP);
    assign wr_ivr  = hit(bus_wr, bus_idx, `MFT_IDX_IVR);

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= bus_req && !WB_ACK_O;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            WB_DAT_O <= {`MFT_RD_PAD, `MFT_RST8};
        end else if (bus_req && !WB_ACK_O) begin
            unique case (bus_idx)
                `MFT_IDX_OBC: WB_DAT_O <= {`MFT_RD_PAD, obc[7:1], OUTPUT_PIN_B};
                `MFT_IDX_FLG: WB_DAT_O <= {`MFT_RD_PAD, flg};
                `MFT_IDX_MSK: WB_DAT_O <= {`MFT_RD_PAD, msk};
                `MFT_IDX_DCP: WB_DAT_O <= {`MFT_RD_PAD, dcp};
                `MFT_IDX_DAP: WB_DAT_O <= {`MFT_RD_PAD, dap};
                `MFT_IDX_IVR: WB_DAT_O <= {`MFT_RD_PAD, ivr_sw, grp, 1'b0};
                default:      WB_DAT_O <= {`MFT_RD_PAD, `MFT_RST8};
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Output pin B and on-chip event
    // ----------------------------------------------------------------
    always_comb begin
        act = mft_pkg::MFT_NOP;
        if (CMP0_MATCH) begin
            act = act & obc[`MFT_OB_C0A];
        end
        if (CMP1_MATCH) begin
            act = act & obc[`MFT_OB_C1A];
        end
        if (CNT_WRAP) begin
            act = act & obc[`MFT_OB_WRA];
        end
        next_pin = apply_act(act, wr_obc ? WB_DAT_I[`MFT_OB_PIN] : OUTPUT_PIN_B);
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            obc          <= `MFT_RST8;
            OUTPUT_PIN_B <= 1'b0;
            CHIP_EVENT   <= 1'b0;
        end else begin
            if (wr_obc) begin
                obc <= WB_DAT_I[7:0];
            end
            OUTPUT_PIN_B <= next_pin;
            CHIP_EVENT   <= CNT_WRAP && obc[`MFT_OB_CEV];
        end
    end

    // ----------------------------------------------------------------
    // Event flags
    // ----------------------------------------------------------------
    always_comb begin
        sw_cap0 = wr_flg && WB_DAT_I[`MFT_FL_CP0];
        sw_cap1 = wr_flg && WB_DAT_I[`MFT_FL_CP1] && !BICAPTURE_MODE;
        cap0_ev = CAP0_EVT || sw_cap0;
        cap1_ev = CAP1_EVT || sw_cap1;
        hw_set  = {cap0_ev, cap1_ev, CMP0_MATCH, CMP1_MATCH, CNT_WRAP,
                   (cap0_ev && flg[`MFT_FL_CP0]) || sw_cap0,
                   CMP0_MATCH && flg[`MFT_FL_CM0]};
        sw_clr  = wr_flg ? ~WB_DAT_I[`MFT_FL_HW] : `MFT_RST7;
        // A hardware set in the clearing cycle is kept.
        next_flg[`MFT_FL_HW] = (flg[`MFT_FL_HW] & ~sw_clr) | hw_set;
        next_flg[`MFT_FL_A0] = wr_flg ? WB_DAT_I[`MFT_FL_A0] : flg[`MFT_FL_A0];
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            flg          <= `MFT_RST8;
            SW_CAP0_LOAD <= 1'b0;
            SW_CAP1      <= 1'b0;
        end else begin
            flg          <= next_flg;
            SW_CAP0_LOAD <= sw_cap0;
            SW_CAP1      <= sw_cap1;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt/DMA mask and DMA requests
    // ----------------------------------------------------------------
    always_comb begin
        next_msk = msk;
        if (CAP0_DMA_EOB) begin
            next_msk[`MFT_MK_CAPTURE0_DMA_EN] = 1'b0;
        end
        if (CMP0_DMA_EOB) begin
            next_msk[`MFT_MK_COMPARE0_DMA_EN] = 1'b0;
        end
        if (wr_msk) begin
            next_msk = WB_DAT_I[7:0];
        end
        dma_c_req = CAP0_EVT && msk[`MFT_MK_CAPTURE0_DMA_EN];
        dma_m_req = CMP0_MATCH && msk[`MFT_MK_COMPARE0_DMA_EN];
        any_eob   = CAP0_DMA_EOB || CMP0_DMA_EOB;
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            msk          <= `MFT_RST8;
            CAP0_DMA_REQ <= 1'b0;
            CMP0_DMA_REQ <= 1'b0;
        end else begin
            msk          <= next_msk;
            CAP0_DMA_REQ <= dma_c_req;
            CMP0_DMA_REQ <= dma_m_req;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt requests and vector
    // ----------------------------------------------------------------
    always_comb begin
        c0_rq  = msk[`MFT_MK_CAPTURE0_IRQ_MASK] && (msk[`MFT_MK_CAPTURE0_DMA_EN] ? eob_cap : flg[`MFT_FL_CP0]);
        c1_rq  = msk[`MFT_MK_CAPTURE1_IRQ_MASK] && flg[`MFT_FL_CP1];
        cap_rq = msk[`MFT_MK_GT] && (flg[`MFT_FL_A0] ? (c0_rq && c1_rq) : (c0_rq || c1_rq));
        cmp_rq = msk[`MFT_MK_GT] &&
                 ((msk[`MFT_MK_COMPARE0_IRQ_MASK] && (msk[`MFT_MK_COMPARE0_DMA_EN] ? eob_cmp : flg[`MFT_FL_CM0])) ||
                  (msk[`MFT_MK_COMPARE1_IRQ_MASK] && flg[`MFT_FL_CM1]));
        wrp_rq = msk[`MFT_MK_GT] && msk[`MFT_MK_OUI] && flg[`MFT_FL_WRP];
        any_rq = cap_rq || cmp_rq || wrp_rq;
        if (wrp_rq) begin
            next_grp = mft_pkg::MFT_GRP_WRAP;
        end else if (cap_rq) begin
            next_grp = mft_pkg::MFT_GRP_CAP;
        end else if (cmp_rq) begin
            next_grp = mft_pkg::MFT_GRP_CMP;
        end else begin
            next_grp = grp;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            IRQ_REQ    <= 1'b0;
            grp        <= mft_pkg::MFT_GRP_WRAP;
            IRQ_VECTOR <= `MFT_RST8;
        end else begin
            IRQ_REQ <= any_rq;
            if (IRQ_ACK && any_rq) begin
                grp        <= next_grp;
                IRQ_VECTOR <= {ivr_sw, next_grp, 1'b0};
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ivr_sw <= `MFT_RST5;
        end else if (wr_ivr) begin
            ivr_sw <= WB_DAT_I[`MFT_IV_SW];
        end
    end

    // End-of-block events held until their group is acknowledged.
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            eob_cap <= 1'b0;
            eob_cmp <= 1'b0;
        end else begin
            eob_cap <= (CAP0_DMA_EOB && msk[`MFT_MK_CAPTURE0_DMA_EN]) ||
                       (eob_cap && !(IRQ_ACK && next_grp == mft_pkg::MFT_GRP_CAP && cap_rq));
            eob_cmp <= (CMP0_DMA_EOB && msk[`MFT_MK_COMPARE0_DMA_EN]) ||
                       (eob_cmp && !(IRQ_ACK && next_grp == mft_pkg::MFT_GRP_CMP && cmp_rq));
        end
    end

    // ----------------------------------------------------------------
    // DMA pointers
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            dcp            <= `MFT_RST8;
            dap            <= `MFT_RST8;
            DMA_TO_REGFILE <= 1'b0;
            DMA_USE_DMASEG <= 1'b0;
            DMA_CHAN_IND   <= 1'b0;
        end else begin
            dcp            <= ptr_next(dcp, wr_dcp);
            dap            <= ptr_next(dap, wr_dap);
            DMA_TO_REGFILE <= dcp[`MFT_DP_SEL];
            DMA_USE_DMASEG <= !dcp[`MFT_DP_SEL] && dap[`MFT_DP_SEL];
            DMA_CHAN_IND   <= dcp[`MFT_DP_IND];
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    sequence s_wrap_ev;
        CNT_WRAP && obc[`MFT_OB_CEV];
    endsequence
    sequence s_one_pulse;
        CHIP_EVENT ##1 (!CHIP_EVENT || $past(CNT_WRAP));
    endsequence

    property p_cmp0_set;
        CMP0_MATCH && !CMP1_MATCH && !CNT_WRAP && !wr_obc && obc[`MFT_OB_C0A] == mft_pkg::MFT_SET
        |=> OUTPUT_PIN_B;
    endproperty
    a_cmp0_set: assert property (p_cmp0_set) else $error("pin B not set on compare 0");

    property p_cmp1_tgl;
        CMP1_MATCH && !CMP0_MATCH && !CNT_WRAP && !wr_obc && obc[`MFT_OB_C1A] == mft_pkg::MFT_TGL
        |=> OUTPUT_PIN_B != $past(OUTPUT_PIN_B);
    endproperty
    a_cmp1_tgl: assert property (p_cmp1_tgl) else $error("pin B not toggled on compare 1");

    property p_wrap_nop;
        CNT_WRAP && !CMP0_MATCH && !CMP1_MATCH && !wr_obc && obc[`MFT_OB_WRA] == mft_pkg::MFT_NOP
        |=> $stable(OUTPUT_PIN_B);
    endproperty
    a_wrap_nop: assert property (p_wrap_nop) else $error("pin B moved on wrap no-op");

    property p_and_codes;
        CMP0_MATCH && CMP1_MATCH && !CNT_WRAP && !wr_obc
        && (obc[`MFT_OB_C0A] & obc[`MFT_OB_C1A]) == mft_pkg::MFT_CLR |=> !OUTPUT_PIN_B;
    endproperty
    a_and_codes: assert property (p_and_codes) else $error("combined action not ANDed");

    property p_chip_event;
        s_wrap_ev |=> s_one_pulse;
    endproperty
    a_chip_event: assert property (p_chip_event) else $error("chip event pulse wrong");

    property p_no_chip_event;
        !(CNT_WRAP && obc[`MFT_OB_CEV]) |=> !CHIP_EVENT;
    endproperty
    a_no_chip_event: assert property (p_no_chip_event) else $error("spurious chip event");

    property p_cap0_flag;
        CAP0_EVT |=> flg[`MFT_FL_CP0];
    endproperty
    a_cap0_flag: assert property (p_cap0_flag) else $error("capture 0 flag not set");

    property p_sw_cap_overrun;
        sw_cap0 |=> flg[`MFT_FL_CAPTURE0_OVERRUN] && SW_CAP0_LOAD;
    endproperty
    a_sw_cap_overrun: assert property (p_sw_cap_overrun) else $error("software capture overrun missing");

    property p_cmp0_overrun;
        CMP0_MATCH && flg[`MFT_FL_CM0] |=> flg[`MFT_FL_COMPARE0_OVERRUN];
    endproperty
    a_cmp0_overrun: assert property (p_cmp0_overrun) else $error("compare 0 overrun missing");

    property p_global_off;
        !msk[`MFT_MK_GT] |=> !IRQ_REQ;
    endproperty
    a_global_off: assert property (p_global_off) else $error("interrupt while globally disabled");

    property p_wrap_irq;
        msk[`MFT_MK_GT] && msk[`MFT_MK_OUI] && flg[`MFT_FL_WRP] |=> IRQ_REQ;
    endproperty
    a_wrap_irq: assert property (p_wrap_irq) else $error("wrap interrupt missing");

    property p_dma_eob_clear;
        CAP0_DMA_EOB && !wr_msk |=> !msk[`MFT_MK_CAPTURE0_DMA_EN];
    endproperty
    a_dma_eob_clear: assert property (p_dma_eob_clear) else $error("capture DMA enable not cleared");

    property p_vector_wrap;
        IRQ_ACK && wrp_rq |=> IRQ_VECTOR[2:0] == 3'h0;
    endproperty
    a_vector_wrap: assert property (p_vector_wrap) else $error("vector group code wrong");

endmodule

// >>> mft_ctl_model.sv
// Behavioural interrupt and DMA controller on the far side of the timer block.
`timescale 1ns/1ps
module mft_ctl_model #(
    parameter int BLOCK = 2 // Transfers in one DMA block.
) (
    input  wire logic clk,     // System clock.
    input  wire logic rstn,    // Reset, active low.
    input  wire logic slow,    // Answer interrupt requests after extra cycles.
    input  wire logic irq_req, // Interrupt request.
    input  wire logic cap_req, // Capture 0 DMA request.
    input  wire logic cmp_req, // Compare 0 DMA request.
    output logic      irq_ack, // Acknowledge pulse.
    output logic      cap_eob, // Capture 0 end of block pulse.
    output logic      cmp_eob  // Compare 0 end of block pulse.
);
    int wait_cnt;
    int cap_cnt;
    int cmp_cnt;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_ack  <= 1'b0;
            wait_cnt <= 0;
        end else begin
            irq_ack  <= 1'b0;
            wait_cnt <= (irq_req && !irq_ack) ? wait_cnt + 1 : 0;
            if (irq_req && !irq_ack && wait_cnt >= (slow ? 3 : 0)) begin
                irq_ack <= 1'b1;
            end
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cap_cnt <= 0;
            cmp_cnt <= 0;
            cap_eob <= 1'b0;
            cmp_eob <= 1'b0;
        end else begin
            cap_cnt <= cap_req ? ((cap_cnt == BLOCK - 1) ? 0 : cap_cnt + 1) : cap_cnt;
            cmp_cnt <= cmp_req ? ((cmp_cnt == BLOCK - 1) ? 0 : cmp_cnt + 1) : cmp_cnt;
            cap_eob <= cap_req && cap_cnt == BLOCK - 1;
            cmp_eob <= cmp_req && cmp_cnt == BLOCK - 1;
        end
    end
endmodule

// >>> test_mft_outb_flags_irq_dma_ctl.sv
// Self-checking bench for the output B, flag, mask and DMA pointer block.
`timescale 1ns/1ps
module test_mft_outb_flags_irq_dma_ctl;
    localparam logic [9:0] DCP = 10'h3c0, DAP = 10'h3c4, IVR = 10'h3c8;
    localparam logic [9:0] OBC = 10'h3f4, FLG = 10'h3f8, MSK = 10'h3fc;
    localparam logic [9:0] ADRS [7] = '{DCP, DAP, IVR, OBC, FLG, MSK, 10'h000};
    localparam logic [16:0] TBL [10] = '{{1'b0, 8'h02, 5'h02, 3'b000}, {1'b0, 8'h82, 5'h02, 3'b111},
        {1'b0, 8'h81, 5'h04, 3'b100}, {1'b0, 8'h84, 5'h01, 3'b111}, {1'b0, 8'ha0, 5'h08, 3'b110},
        {1'b0, 8'h90, 5'h10, 3'b110}, {1'b0, 8'h85, 5'h05, 3'b100}, {1'b1, 8'hb0, 5'h08, 3'b000},
        {1'b1, 8'hb0, 5'h18, 3'b110}, {1'b0, 8'h80, 5'h1f, 3'b000}};
    logic        clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, slow = 0, bicap = 0, swap = 0;
    logic [9:0]  adr = '0;
    logic [31:0] wdat = '0, rdat;
    logic [4:0]  ev = '0;
    logic        ack, pin, cev, irq, iack, cdreq, mdreq, ceob, meob, sw0, sw1, regf, dseg, ind;
    logic [7:0]  vec;
    logic [31:0] exp_q [$];
    int          num_errors = 0, n_compared = 0;
    mft_outb_flags_irq_dma_ctl i_dut (.SYS_CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .CMP0_MATCH(ev[0]), .CMP1_MATCH(ev[1]), .CNT_WRAP(ev[2]), .CAP0_EVT(ev[3]), .CAP1_EVT(ev[4]),
        .BICAPTURE_MODE(bicap), .TABLE_SWAP_EN(swap), .CAP0_DMA_EOB(ceob), .CMP0_DMA_EOB(meob),
        .IRQ_ACK(iack), .OUTPUT_PIN_B(pin), .CHIP_EVENT(cev), .IRQ_REQ(irq), .IRQ_VECTOR(vec),
        .CAP0_DMA_REQ(cdreq), .CMP0_DMA_REQ(mdreq), .SW_CAP0_LOAD(sw0), .SW_CAP1(sw1),
        .DMA_TO_REGFILE(regf), .DMA_USE_DMASEG(dseg), .DMA_CHAN_IND(ind));
    mft_ctl_model #(.BLOCK(2)) i_ctl (.clk(clk), .rstn(rstn), .slow(slow), .irq_req(irq),
        .cap_req(cdreq), .cmp_req(mdreq), .irq_ack(iack), .cap_eob(ceob), .cmp_eob(meob));
    initial forever #25 clk = ~clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            num_errors++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(1'b0, a, 8'h00);
    endtask
    task automatic pulse(input logic [4:0] e);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= '0;
        #1;
    endtask
    function automatic logic act(input logic [1:0] c, input logic p);
        return (c == 2'b00) | ((c == 2'b01) & !p) | ((c == 2'b11) & p);
    endfunction
    task automatic print_verdict;
        if (num_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Read results are compared against the oldest noted expectation.
    always @(posedge clk) if (ack === 1'b1 && we === 1'b0) check(rdat, exp_q.pop_front());
    initial begin
        #2_000_000;
        num_errors++;
        print_verdict();
    end
    initial begin
        logic [7:0]  r, v;
        logic [16:0] t;
        void'($urandom(4945));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        foreach (ADRS[i]) rd(ADRS[i], 8'h00);
        for (int k = 0; k < 12; k++) begin
            r = {6'h3f, 2'($urandom)};
            r[7 - 2 * (k / 4) -: 2] = 2'(k % 4);
            bus(1'b1, OBC, r);
            pulse(5'(1 << (k / 4)));
            check(pin, act(2'(k % 4), r[0]));
            check(cev, r[1] && k / 4 == 2);
            rd(OBC, {r[7:1], act(2'(k % 4), r[0])});
        end
        repeat (8) begin
            r = 8'($urandom);
            bus(1'b1, OBC, r);
            pulse(5'b00111);
            check(pin, act(r[7:6] & r[5:4] & r[3:2], r[0]));
        end
        bus(1'b1, FLG, 8'h00);
        pulse(5'b00001);
        pulse(5'b01001);
        pulse(5'b11110);
        rd(FLG, 8'hfe);
        for (int b = 0; b < 2; b++) begin
            bicap <= b[0];
            bus(1'b1, FLG, 8'h00);
            bus(1'b1, FLG, 8'hc0);
            #1;
            check(sw0, 1'b1);
            check(sw1, !b[0]);
        end
        rd(FLG, 8'h84);
        v = 8'($urandom);
        bus(1'b1, IVR, v);
        foreach (TBL[i]) begin
            t = TBL[i];
            slow <= i[0];
            bus(1'b1, FLG, {7'h00, t[16]});
            bus(1'b1, MSK, t[15:8]);
            pulse(t[7:3]);
            repeat (8) @(posedge clk);
            #1;
            check(irq, t[2]);
            if (t[2]) check(vec, {v[7:3], t[1:0], 1'b0});
        end
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, DCP, {7'h00, c[0]});
            bus(1'b1, DAP, {7'h00, c[1]});
            repeat (2) @(posedge clk);
            #1;
            check(regf, c[0]);
            check(dseg, !c[0] && c[1]);
        end
        swap <= 1'b1;
        bus(1'b1, DCP, 8'h10);
        bus(1'b1, FLG, 8'h00);
        for (int d = 0; d < 2; d++) begin
            bus(1'b1, MSK, d ? 8'h40 : 8'h08);
            repeat (2) begin
                pulse(d ? 5'b01000 : 5'b00001);
                check(d ? cdreq : mdreq, 1'b1);
            end
            repeat (4) @(posedge clk);
            rd(MSK, 8'h00);
            rd(DCP, d ? 8'h10 : 8'h16);
            rd(DAP, d ? 8'h01 : 8'h07);
            check(ind, !d);
        end
        repeat (2) @(posedge clk);
        print_verdict();
    end
endmodule
